// *** src/bss_pkg.sv ***
// Constants and enumerations shared by the boot source selection files
package bss_pkg;

  // Option bit positions and count
  localparam int unsigned NVB_W        = 2;
  localparam int unsigned NVB_SECURITY = 0;
  localparam int unsigned NVB_BOOT     = 1;

  // Option bits after power-up: ROM boot, security off
  localparam logic [1:0] NVB_RESET = 2'h0;

  // Fixed fetch address of the first instruction
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

  // Boot source encodings on the map output
  localparam logic BOOT_SRC_ROM   = 1'b0;
  localparam logic BOOT_SRC_FLASH = 1'b1;

  // Clock rate and least wipe hold time
  localparam int unsigned CLK_KHZ     = 125000;
  localparam int unsigned WIPE_MIN_MS = 200;
  // Least hold rounded up to whole cycles
  localparam int unsigned WIPE_CYCLES = WIPE_MIN_MS * CLK_KHZ;
  // Counter width wide enough for WIPE_CYCLES
  localparam int unsigned WIPE_CNT_W  = 25;

  // Wipe sequence states
  typedef enum logic [0:0] {
    BSS_WIPE_IDLE  = 1'b0,
    BSS_WIPE_ARMED = 1'b1
  } bss_wipe_st_t;

endpackage

// *** src/bss_top.sv ***
// Boot source selection: option bits, boot map, security gate
// Summary of operation
// - Two option bits, set by command; only the boot bit cleared by command
// - First fetch always at address zero
// - Bit one set maps flash at zero
// - Bit one clear maps ROM at zero
// - ROM boot is the power-up default
// - Wipe pin clears boot bit to ROM
// - Security bit blocks debug and parallel access
// - Security set by command, cleared by wipe+erase
`timescale 1ns/1ns
`default_nettype none
module bss_top
  import bss_pkg::*;
#(
  parameter int unsigned WIPE_HOLD = bss_pkg::WIPE_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sys_rst_req,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_set,
  input  wire logic [0:0]  cmd_bit,
  input  wire logic        full_erase_done,
  input  wire logic        wipe_pin,
  input  wire logic        dbg_req,
  input  wire logic        ffpi_req,
  output logic [1:0]       nv_option_bit,
  output logic             boot_src,
  output logic [31:0]      boot_fetch_addr,
  output logic             security_on,
  output logic             dbg_grant,
  output logic             ffpi_grant,
  output logic             cmd_done,
  output logic             cmd_err,
  output logic             erase_req
);

  // Whole controller state
  typedef struct packed {
    logic [NVB_W-1:0] nv;         // Option bits
    bss_wipe_st_t     st;         // Wipe sequence state
    logic             boot_src;   // Memory mapped at zero
    logic [31:0]      fetch;      // First fetch address
    logic             dbg_g;      // Debug port grant
    logic             ffpi_g;     // Parallel port grant
    logic             done;       // Command accepted pulse
    logic             err;        // Command refused pulse
    logic             erase_req;  // Full erase request pulse
  } bss_state_t;

  bss_state_t s_r;
  bss_state_t s_nxt;

  bss_wipe_if wif ();

  // Pin level straight to the hold timer
  assign wif.wipe_level = wipe_pin;

  // Hold timer for the wipe pin
  bss_wipe_timer #(
    .WIPE_HOLD (WIPE_HOLD)
  ) u_wipe (
    .core_clk (core_clk),
    .rst      (rst),
    .wif      (wif)
  );

  // Command decodes
  logic set_sec;    // Set security bit
  logic set_boot;   // Set boot bit
  logic clr_boot;   // Clear boot bit
  logic clr_sec;    // Refused clear of security bit
  logic erase_clr;  // Erase completes an armed wipe

  always_comb begin
    set_sec   = cmd_valid && cmd_set && (cmd_bit == 1'(NVB_SECURITY));
    set_boot  = cmd_valid && cmd_set && (cmd_bit == 1'(NVB_BOOT));
    clr_boot  = cmd_valid && !cmd_set && (cmd_bit == 1'(NVB_BOOT));
    clr_sec   = cmd_valid && !cmd_set && (cmd_bit == 1'(NVB_SECURITY));
    erase_clr = (s_r.st == BSS_WIPE_ARMED) && full_erase_done;
  end

  // Next state
  always_comb begin
    s_nxt           = s_r;
    s_nxt.done      = 1'b0;
    s_nxt.err       = 1'b0;
    s_nxt.erase_req = 1'b0;
    s_nxt.fetch     = BOOT_ADDR;

    if (cmd_valid) begin
      s_nxt.done = !clr_sec;
      s_nxt.err  = clr_sec;
    end
    if (clr_boot || wif.wipe_done) begin
      s_nxt.nv[NVB_BOOT] = 1'b0;
    end
    // Set wins over a same-cycle clear
    if (set_boot) begin
      s_nxt.nv[NVB_BOOT] = 1'b1;
    end

    // wipe then full erase clears security
    case (s_r.st)
      BSS_WIPE_IDLE: begin
        if (wif.wipe_done) begin
          s_nxt.st        = BSS_WIPE_ARMED;
          s_nxt.erase_req = 1'b1;
        end
      end
      BSS_WIPE_ARMED: begin
        if (full_erase_done) begin
          s_nxt.st               = BSS_WIPE_IDLE;
          s_nxt.nv[NVB_SECURITY] = 1'b0;
        end
      end
      default: begin
        s_nxt.st = BSS_WIPE_IDLE;
      end
    endcase
    // security set only by command, set wins
    if (set_sec) begin
      s_nxt.nv[NVB_SECURITY] = 1'b1;
    end

    // map follows the boot bit only in reset
    if (sys_rst_req) begin
      // flash when set, ROM when clear
      s_nxt.boot_src = s_r.nv[NVB_BOOT] ? BOOT_SRC_FLASH : BOOT_SRC_ROM;
    end

    s_nxt.dbg_g  = dbg_req && !s_r.nv[NVB_SECURITY];
    s_nxt.ffpi_g = ffpi_req && !s_r.nv[NVB_SECURITY];
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r.nv        <= NVB_RESET;
      s_r.st        <= BSS_WIPE_IDLE;
      s_r.boot_src  <= BOOT_SRC_ROM;
      s_r.fetch     <= BOOT_ADDR;
      s_r.dbg_g     <= 1'b0;
      s_r.ffpi_g    <= 1'b0;
      s_r.done      <= 1'b0;
      s_r.err       <= 1'b0;
      s_r.erase_req <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign nv_option_bit   = s_r.nv;
  assign boot_src        = s_r.boot_src;
  assign boot_fetch_addr = s_r.fetch;
  assign security_on     = s_r.nv[NVB_SECURITY];
  assign dbg_grant       = s_r.dbg_g;
  assign ffpi_grant      = s_r.ffpi_g;
  assign cmd_done        = s_r.done;
  assign cmd_err         = s_r.err;
  assign erase_req       = s_r.erase_req;

  // Checks on the design's own behaviour
  set_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid && cmd_set |=> nv_option_bit[$past(cmd_bit)] && cmd_done)
    else $error("set command did not set its bit");

  clr_boot_a: assert property (@(posedge core_clk) disable iff (rst)
    clr_boot |=> !nv_option_bit[NVB_BOOT] && cmd_done)
    else $error("clear command did not clear boot bit");

  fetch_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 boot_fetch_addr == BOOT_ADDR)
    else $error("first fetch address is not zero");

  map_flash_a: assert property (@(posedge core_clk) disable iff (rst)
    sys_rst_req && nv_option_bit[NVB_BOOT] |=> boot_src == BOOT_SRC_FLASH)
    else $error("flash not mapped with boot bit set");

  map_rom_a: assert property (@(posedge core_clk) disable iff (rst)
    sys_rst_req && !nv_option_bit[NVB_BOOT] |=> boot_src == BOOT_SRC_ROM)
    else $error("ROM not mapped with boot bit clear");

  rom_default_a: assert property (@(posedge core_clk)
    rst |=> !nv_option_bit[NVB_BOOT] && boot_src == BOOT_SRC_ROM)
    else $error("power-up default is not ROM boot");

  wipe_boot_a: assert property (@(posedge core_clk) disable iff (rst)
    wif.wipe_done && !set_boot |=> !nv_option_bit[NVB_BOOT] && erase_req)
    else $error("wipe did not clear boot bit");

  sec_block_a: assert property (@(posedge core_clk) disable iff (rst)
    nv_option_bit[NVB_SECURITY] |=> !dbg_grant && !ffpi_grant)
    else $error("access granted while secured");

  sec_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    nv_option_bit[NVB_SECURITY] && !erase_clr |=> nv_option_bit[NVB_SECURITY])
    else $error("security bit cleared without wipe and erase");

  sec_clr_a: assert property (@(posedge core_clk) disable iff (rst)
    clr_sec |=> cmd_err && !cmd_done)
    else $error("security clear command not refused");

  map_frozen_a: assert property (@(posedge core_clk) disable iff (rst)
    !sys_rst_req |=> $stable(boot_src))
    else $error("boot map changed outside reset");

endmodule
`default_nettype wire

// *** src/bss_wipe_if.sv ***
// Carrier between the controller and the wipe hold timer
`timescale 1ns/1ns
`default_nettype none
interface bss_wipe_if;
  logic wipe_level;   // Wipe pin level, high while asserted
  logic wipe_done;    // One-cycle pulse when hold time is met

  // Timer side
  modport timer (input wipe_level, output wipe_done);
  // Controller side
  modport ctrl (output wipe_level, input wipe_done);
endinterface
`default_nettype wire

// *** src/bss_wipe_timer.sv ***
// Wipe pin hold timer: pulses once per long enough assertion
`timescale 1ns/1ns
`default_nettype none
module bss_wipe_timer
  import bss_pkg::*;
#(
  parameter int unsigned WIPE_HOLD = bss_pkg::WIPE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  bss_wipe_if.timer wif
);

  // Timer state
  typedef struct packed {
    logic [WIPE_CNT_W-1:0] cnt;    // Cycles the pin has been high
    logic                  fired;  // Pulse already given this assertion
    logic                  done;   // Hold met pulse
  } bss_tmr_t;

  bss_tmr_t s_r;
  bss_tmr_t s_nxt;

  localparam logic [WIPE_CNT_W-1:0] HOLD_LAST = WIPE_CNT_W'(WIPE_HOLD - 1);

  // Next state: count while high, restart on release
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (!wif.wipe_level) begin
      s_nxt.cnt   = '0;
      s_nxt.fired = 1'b0;
    end else if (!s_r.fired) begin
      if (s_r.cnt == HOLD_LAST) begin
        s_nxt.done  = 1'b1;
        s_nxt.fired = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wif.wipe_done = s_r.done;

endmodule
`default_nettype wire

// *** tb/bss_top_test.sv ***
// Self-checking testbench for the boot source selection block
`timescale 1ns/1ns
`default_nettype none
module bss_top_test;
  import bss_pkg::*;

  // Shortened wipe hold so the run stays brief
  localparam int unsigned HOLD = 8;

  logic        core_clk;         // Core clock, 8 ns period
  logic        rst;              // Power-up reset, active high
  logic        sys_rst_req;      // Opens boot map sampling
  logic        cmd_valid;        // Command strobe
  logic        cmd_set;          // Set or clear
  logic [0:0]  cmd_bit;          // Option bit index
  logic        full_erase_done;  // Erase finished pulse
  logic        wipe_pin;         // Wipe pin level
  logic        dbg_req;          // Debug access request
  logic        ffpi_req;         // Parallel port request
  logic [1:0]  nv_option_bit;    // Option bits seen
  logic        boot_src;         // Memory at address zero
  logic [31:0] boot_fetch_addr;  // First fetch address
  logic        security_on;      // Security state
  logic        dbg_grant;        // Debug grant
  logic        ffpi_grant;       // Parallel port grant
  logic        cmd_done;         // Command accepted
  logic        cmd_err;          // Command refused
  logic        erase_req;        // Full erase request
  int          failures;         // Mismatch count
  int          check_count;      // Comparison count
  int          pulses;           // Erase requests seen in a wipe

  bss_top #(.WIPE_HOLD(HOLD)) dut_u (
    .core_clk(core_clk), .rst(rst), .sys_rst_req(sys_rst_req), .cmd_valid(cmd_valid),
    .cmd_set(cmd_set), .cmd_bit(cmd_bit), .full_erase_done(full_erase_done),
    .wipe_pin(wipe_pin), .dbg_req(dbg_req), .ffpi_req(ffpi_req),
    .nv_option_bit(nv_option_bit), .boot_src(boot_src), .boot_fetch_addr(boot_fetch_addr),
    .security_on(security_on), .dbg_grant(dbg_grant), .ffpi_grant(ffpi_grant),
    .cmd_done(cmd_done), .cmd_err(cmd_err), .erase_req(erase_req)
  );

  // Free running clock
  always #4 core_clk = ~core_clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One clock, then settle
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // One command strobe; outputs are settled on return
  task automatic cmd(input logic s, input logic [0:0] b);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_set   <= s;
    cmd_bit   <= b;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  // System reset window of one cycle
  task automatic sys_reset;
    @(posedge core_clk);
    sys_rst_req <= 1'b1;
    @(posedge core_clk);
    sys_rst_req <= 1'b0;
    #1;
  endtask

  // Hold the wipe pin n+1 cycles and count erase requests
  task automatic wipe(input int n);
    pulses = 0;
    @(posedge core_clk);
    wipe_pin <= 1'b1;
    repeat (n) begin
      tick();
      if (erase_req === 1'b1) pulses++;
    end
    @(posedge core_clk);
    wipe_pin <= 1'b0;
    repeat (3) begin
      tick();
      if (erase_req === 1'b1) pulses++;
    end
  endtask

  // Erase finished pulse
  task automatic erase_pulse;
    @(posedge core_clk);
    full_erase_done <= 1'b1;
    @(posedge core_clk);
    full_erase_done <= 1'b0;
    tick();
  endtask

  // Values straight after reset
  task automatic t_defaults;
    chk(32'(nv_option_bit), 32'(NVB_RESET));
    chk(32'(boot_src), 32'(BOOT_SRC_ROM));
    chk(boot_fetch_addr, BOOT_ADDR);
    chk(32'(security_on), 32'h0000_0000);
    $display("test defaults done");
  endtask

  // Select flash boot; map moves only in a reset window
  task automatic t_boot_flash;
    cmd(1'b1, 1'b1);
    chk(32'(cmd_done), 32'h0000_0001);
    chk(32'(nv_option_bit), 32'h0000_0002);
    chk(32'(boot_src), 32'(BOOT_SRC_ROM));
    sys_reset();
    chk(32'(boot_src), 32'(BOOT_SRC_FLASH));
    chk(boot_fetch_addr, BOOT_ADDR);
    $display("test boot_flash done");
  endtask

  // Short wipe ignored, long wipe returns to ROM boot
  task automatic t_wipe;
    wipe(HOLD - 3);
    chk(32'(pulses), 32'h0000_0000);
    chk(32'(nv_option_bit), 32'h0000_0002);
    wipe(HOLD + 4);
    chk(32'(pulses), 32'h0000_0001);
    chk(32'(nv_option_bit), 32'h0000_0000);
    chk(32'(boot_src), 32'(BOOT_SRC_FLASH));
    sys_reset();
    chk(32'(boot_src), 32'(BOOT_SRC_ROM));
    // Answer the erase request so no wipe stays pending
    erase_pulse();
    chk(32'(nv_option_bit), 32'h0000_0000);
    $display("test wipe done");
  endtask

  // Security gates access; clear only by wipe then erase
  task automatic t_security;
    @(posedge core_clk);
    dbg_req  <= 1'b1;
    ffpi_req <= 1'b1;
    cmd(1'b1, 1'b0);
    chk(32'({dbg_grant, ffpi_grant}), 32'h0000_0003);
    chk(32'(security_on), 32'h0000_0001);
    tick();
    chk(32'({dbg_grant, ffpi_grant}), 32'h0000_0000);
    cmd(1'b0, 1'b0);
    chk(32'({cmd_err, cmd_done}), 32'h0000_0002);
    erase_pulse();
    chk(32'(nv_option_bit), 32'h0000_0001);
    wipe(HOLD + 4);
    erase_pulse();
    chk(32'(nv_option_bit), 32'h0000_0000);
    tick();
    chk(32'({dbg_grant, ffpi_grant}), 32'h0000_0003);
    $display("test security done");
  endtask

  // Boot bit clear command, then a mid-run reset back to defaults
  task automatic t_reset;
    cmd(1'b1, 1'b1);
    chk(32'(nv_option_bit), 32'h0000_0002);
    cmd(1'b0, 1'b1);
    chk(32'({cmd_err, cmd_done}), 32'h0000_0001);
    chk(32'(nv_option_bit), 32'h0000_0000);
    cmd(1'b1, 1'b1);
    sys_reset();
    chk(32'(boot_src), 32'(BOOT_SRC_FLASH));
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    tick();
    chk(32'(nv_option_bit), 32'(NVB_RESET));
    chk(32'(boot_src), 32'(BOOT_SRC_ROM));
    // First command right after release
    cmd(1'b1, 1'b1);
    chk(32'(nv_option_bit), 32'h0000_0002);
    $display("test reset done");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    sys_rst_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_set = 1'b0;
    cmd_bit = 1'b0;
    full_erase_done = 1'b0;
    wipe_pin = 1'b0;
    dbg_req = 1'b0;
    ffpi_req = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick();
    t_defaults();
    t_boot_flash();
    t_wipe();
    t_security();
    t_reset();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
